// ==== design/dcb_adc_dev.sv ====
`timescale 1ns/1ps
// How it works
// - daisy mode: chain input low or tied
// - conversion timed by own clock
// - drive chain output low when both low
// - trigger rise: select mode, sample, convert
// - host holds trigger high until read
// - conversion ignores serial clock
// - host holds sclk high at trigger rise
// - end: load result; in daisy mode, chain output high in busy mode, else result msb
// - power down at conversion end, acquire
// - power up at next conversion start
// - previous result stays readable during acquisition
// - each sclk fall in daisy mode: latch input, shift out; the first fall in busy mode only shifts out the msb
// - interrupt, last device first, msb first
// - host issues eighteen falls per device plus one
// - output bits valid on both edges
// - upstream busy bits are not forwarded
// - fixed conversion time, only idle grows
// - common trigger and common serial clock
// - first input tied to trigger, chained outputs
module dcb_adc_dev (
   input wire logic i_clk,
   input wire logic i_rst_n,
   dcb_link_if.device link,
   input wire logic [dcb_pkg::RES_W-1:0] i_sample_value,
   output logic o_powered_up,
   output logic o_daisy_mode,
   output logic o_busy_mode,
   output logic o_result_ready,
   output logic [dcb_pkg::RES_W-1:0] o_last_result
);

   // ********************************************************************
   // pin synchronisers
   // ********************************************************************
   logic trig_lvl;
   logic trig_rise;
   logic trig_fall;
   logic sclk_lvl;
   logic sclk_fall;
   logic din_lvl;
   logic din_rise;

   dcb_sync u_trig (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_async(link.sample_trigger),
      .o_level(trig_lvl),
      .o_rise(trig_rise),
      .o_fall(trig_fall)
   );

   dcb_sync u_sclk (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_async(link.sclk),
      .o_level(sclk_lvl),
      .o_rise(),
      .o_fall(sclk_fall)
   );

   dcb_sync u_din (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_async(link.chain_in),
      .o_level(din_lvl),
      .o_rise(din_rise),
      .o_fall()
   );

   // ********************************************************************
   // control state
   // ********************************************************************
   dcb_pkg::dcb_dev_state_e state_q;
   dcb_pkg::dcb_dev_state_e state_d;
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   logic daisy_q;
   logic daisy_d;
   logic busy_q;
   logic busy_d;
   logic first_q;
   logic first_d;
   logic pwr_q;
   logic pwr_d;
   logic dout_q;
   logic dout_d;
   logic rdy_q;
   logic rdy_d;
   logic [dcb_pkg::RES_W-1:0] sample_q;
   logic [dcb_pkg::RES_W-1:0] sample_d;
   logic [dcb_pkg::RES_W-1:0] shreg_q;
   logic [dcb_pkg::RES_W-1:0] shreg_d;
   logic [dcb_pkg::RES_W-1:0] res_q;
   logic [dcb_pkg::RES_W-1:0] res_d;

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      daisy_d = daisy_q;
      busy_d = busy_q;
      first_d = first_q;
      pwr_d = pwr_q;
      dout_d = dout_q;
      rdy_d = 1'b0;
      sample_d = sample_q;
      shreg_d = shreg_q;
      res_d = res_q;
      case (state_q)
         dcb_pkg::DS_ACQ: begin
            if (!trig_lvl && !din_lvl) begin
               dout_d = 1'b0;
            end
            if (trig_rise) begin
               state_d = dcb_pkg::DS_CONV;
               cnt_d = dcb_pkg::CNT_ZERO;
               daisy_d = ~din_lvl | din_rise;
               busy_d = sclk_lvl;
               sample_d = i_sample_value;
               pwr_d = 1'b1;
            end
         end
         dcb_pkg::DS_CONV: begin
            cnt_d = cnt_q + dcb_pkg::CNT_ONE;
            if (cnt_q == dcb_pkg::CONV_LAST) begin
               state_d = dcb_pkg::DS_READ;
               pwr_d = 1'b0;
               shreg_d = sample_q;
               res_d = sample_q;
               rdy_d = 1'b1;
               first_d = busy_q;
               if (daisy_q) begin
                  dout_d = busy_q ? 1'b1 : sample_q[dcb_pkg::RES_W-1];
               end
            end
         end
         dcb_pkg::DS_READ: begin
            if (trig_fall) begin
               state_d = dcb_pkg::DS_ACQ;
            end else if (sclk_fall && daisy_q) begin
               if (first_q) begin
                  first_d = 1'b0;
                  dout_d = shreg_q[dcb_pkg::RES_W-1];
               end else begin
                  dout_d = shreg_q[dcb_pkg::RES_W-2];
                  shreg_d = {shreg_q[dcb_pkg::RES_W-2:0], din_lvl};
               end
            end
         end
         default: begin
            state_d = dcb_pkg::DS_ACQ;
         end
      endcase
   end

   // ********************************************************************
   // registers
   // ********************************************************************
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_q <= dcb_pkg::DS_ACQ;
         cnt_q <= dcb_pkg::CNT_ZERO;
         daisy_q <= 1'b0;
         busy_q <= 1'b0;
         first_q <= 1'b0;
         pwr_q <= 1'b0;
         dout_q <= 1'b0;
         rdy_q <= 1'b0;
         sample_q <= dcb_pkg::RES_ZERO;
         shreg_q <= dcb_pkg::RES_ZERO;
         res_q <= dcb_pkg::RES_ZERO;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         daisy_q <= daisy_d;
         busy_q <= busy_d;
         first_q <= first_d;
         pwr_q <= pwr_d;
         dout_q <= dout_d;
         rdy_q <= rdy_d;
         sample_q <= sample_d;
         shreg_q <= shreg_d;
         res_q <= res_d;
      end
   end

   // ********************************************************************
   // outputs
   // ********************************************************************
   // held from fall to fall
   assign link.chain_out = dout_q;
   assign o_last_result = res_q;
   assign o_powered_up = pwr_q;
   assign o_daisy_mode = daisy_q;
   assign o_busy_mode = busy_q;
   assign o_result_ready = rdy_q;

endmodule

// ==== design/dcb_host.sv ====
`timescale 1ns/1ps
module dcb_host (
   input wire logic i_clk,
   input wire logic i_rst_n,
   dcb_link_if.host link,
   input wire logic i_start,
   output logic o_ready,
   output logic o_irq_seen,
   output logic [dcb_pkg::RES_W-1:0] o_word,
   output logic o_word_valid,
   output logic [dcb_pkg::IDX_W-1:0] o_word_index,
   output logic o_done
);

   logic out_lvl;
   logic out_rise;

   dcb_sync u_dout (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_async(link.chain_out),
      .o_level(out_lvl),
      .o_rise(out_rise),
      .o_fall()
   );

   // ********************************************************************
   // sequencer
   // ********************************************************************
   dcb_pkg::dcb_host_state_e state_q;
   dcb_pkg::dcb_host_state_e state_d;
   logic trig_q;
   logic trig_d;
   logic sclk_q;
   logic sclk_d;
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   logic [15:0] falls_q;
   logic [15:0] falls_d;
   logic [4:0] bit_q;
   logic [4:0] bit_d;
   logic [dcb_pkg::RES_W-1:0] acc_q;
   logic [dcb_pkg::RES_W-1:0] acc_d;
   logic [dcb_pkg::RES_W-1:0] word_q;
   logic [dcb_pkg::RES_W-1:0] word_d;
   logic [dcb_pkg::IDX_W-1:0] idx_q;
   logic [dcb_pkg::IDX_W-1:0] idx_d;
   logic [dcb_pkg::IDX_W-1:0] next_idx_q;
   logic [dcb_pkg::IDX_W-1:0] next_idx_d;
   logic valid_q;
   logic valid_d;
   logic ready_q;
   logic ready_d;
   logic irq_q;
   logic irq_d;
   logic done_q;
   logic done_d;

   always_comb begin
      state_d = state_q;
      trig_d = trig_q;
      sclk_d = sclk_q;
      cnt_d = cnt_q;
      falls_d = falls_q;
      bit_d = bit_q;
      acc_d = acc_q;
      word_d = word_q;
      idx_d = idx_q;
      next_idx_d = next_idx_q;
      valid_d = 1'b0;
      ready_d = ready_q;
      irq_d = 1'b0;
      done_d = 1'b0;
      case (state_q)
         dcb_pkg::HS_IDLE: begin
            // trigger low long enough for every device to see it
            // sclk high at trigger rise
            sclk_d = 1'b1;
            if (cnt_q != dcb_pkg::HALF_LAST) begin
               cnt_d = cnt_q + dcb_pkg::CNT_ONE;
            end else begin
               ready_d = 1'b1;
            end
            if (ready_q && i_start) begin
               ready_d = 1'b0;
               trig_d = 1'b1;
               state_d = dcb_pkg::HS_WAIT_IRQ;
            end
         end
         dcb_pkg::HS_WAIT_IRQ: begin
            if (out_rise) begin
               irq_d = 1'b1;
               cnt_d = dcb_pkg::CNT_ZERO;
               falls_d = dcb_pkg::CNT_ZERO;
               bit_d = dcb_pkg::BIT_ZERO;
               next_idx_d = dcb_pkg::IDX_ZERO;
               state_d = dcb_pkg::HS_HIGH;
            end
         end
         dcb_pkg::HS_HIGH: begin
            cnt_d = cnt_q + dcb_pkg::CNT_ONE;
            if (cnt_q == dcb_pkg::HALF_LAST) begin
               cnt_d = dcb_pkg::CNT_ZERO;
               // sample late in the high phase, just before the next fall
               if (falls_q != dcb_pkg::CNT_ZERO &&
                   falls_q <= dcb_pkg::DATA_FALLS) begin
                  acc_d = {acc_q[dcb_pkg::RES_W-2:0], out_lvl};
                  bit_d = bit_q + 5'h01;
                  if (bit_q == dcb_pkg::BIT_LAST) begin
                     bit_d = dcb_pkg::BIT_ZERO;
                     word_d = {acc_q[dcb_pkg::RES_W-2:0], out_lvl};
                     idx_d = next_idx_q;
                     next_idx_d = next_idx_q + dcb_pkg::IDX_ONE;
                     valid_d = 1'b1;
                  end
               end
               if (falls_q == dcb_pkg::FALLS_LAST) begin
                  trig_d = 1'b0;
                  done_d = 1'b1;
                  state_d = dcb_pkg::HS_IDLE;
               end else begin
                  sclk_d = 1'b0;
                  falls_d = falls_q + dcb_pkg::CNT_ONE;
                  state_d = dcb_pkg::HS_LOW;
               end
            end
         end
         dcb_pkg::HS_LOW: begin
            cnt_d = cnt_q + dcb_pkg::CNT_ONE;
            if (cnt_q == dcb_pkg::HALF_LAST) begin
               cnt_d = dcb_pkg::CNT_ZERO;
               sclk_d = 1'b1;
               state_d = dcb_pkg::HS_HIGH;
            end
         end
         default: begin
            state_d = dcb_pkg::HS_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_q <= dcb_pkg::HS_IDLE;
         trig_q <= 1'b0;
         sclk_q <= 1'b1;
         cnt_q <= dcb_pkg::CNT_ZERO;
         falls_q <= dcb_pkg::CNT_ZERO;
         bit_q <= dcb_pkg::BIT_ZERO;
         acc_q <= dcb_pkg::RES_ZERO;
         word_q <= dcb_pkg::RES_ZERO;
         idx_q <= dcb_pkg::IDX_ZERO;
         next_idx_q <= dcb_pkg::IDX_ZERO;
         valid_q <= 1'b0;
         ready_q <= 1'b0;
         irq_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         state_q <= state_d;
         trig_q <= trig_d;
         sclk_q <= sclk_d;
         cnt_q <= cnt_d;
         falls_q <= falls_d;
         bit_q <= bit_d;
         acc_q <= acc_d;
         word_q <= word_d;
         idx_q <= idx_d;
         next_idx_q <= next_idx_d;
         valid_q <= valid_d;
         ready_q <= ready_d;
         irq_q <= irq_d;
         done_q <= done_d;
      end
   end

   // ********************************************************************
   // outputs; first chain input follows the common trigger
   // ********************************************************************
   // one common trigger line
   assign link.sample_trigger = trig_q;
   assign link.chain_in = trig_q;
   assign link.sclk = sclk_q;
   assign o_ready = ready_q;
   assign o_irq_seen = irq_q;
   assign o_word = word_q;
   assign o_word_valid = valid_q;
   assign o_word_index = idx_q;
   assign o_done = done_q;

endmodule

// ==== design/dcb_link_if.sv ====
`timescale 1ns/1ps
interface dcb_link_if;
   logic sample_trigger;
   logic sclk;
   logic chain_in;
   logic chain_out;

   modport device (
      input sample_trigger,
      input sclk,
      input chain_in,
      output chain_out
   );

   modport host (
      output sample_trigger,
      output sclk,
      output chain_in,
      input chain_out
   );
endinterface

// ==== design/dcb_pkg.sv ====
package dcb_pkg;

   // ********************************************************************
   // conversion result and chain geometry
   // ********************************************************************
   localparam int RES_W = 18;
   localparam int CHAIN_DEVICES = 2;
   localparam int TOTAL_FALLS = RES_W * CHAIN_DEVICES + 1;
   localparam int IDX_W = 8;

   // ********************************************************************
   // timing
   // ********************************************************************
   localparam int CLK_PERIOD_NS = 20;
   // fixed conversion time, independent of the serial clock
   localparam int CONV_TIME_NS = 1000;
   localparam int CONV_CYCLES =
      (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // host serial clock half period; long enough for both synchronisers
   localparam int SCLK_HALF_NS = 160;
   localparam int SCLK_HALF_CYCLES = SCLK_HALF_NS / CLK_PERIOD_NS;

   localparam logic [15:0] CONV_LAST = 16'(CONV_CYCLES - 1);
   localparam logic [15:0] CNT_ZERO = 16'h0000;
   localparam logic [15:0] CNT_ONE = 16'h0001;
   localparam logic [15:0] HALF_LAST = 16'(SCLK_HALF_CYCLES - 1);
   localparam logic [15:0] FALLS_LAST = 16'(TOTAL_FALLS);
   localparam logic [15:0] DATA_FALLS = 16'(RES_W * CHAIN_DEVICES);
   localparam logic [4:0] BIT_ZERO = 5'h00;
   localparam logic [4:0] BIT_LAST = 5'(RES_W - 1);
   localparam logic [RES_W-1:0] RES_ZERO = 18'h0_0000;
   localparam logic [IDX_W-1:0] IDX_ZERO = 8'h00;
   localparam logic [IDX_W-1:0] IDX_ONE = 8'h01;

   // ********************************************************************
   // state encodings
   // ********************************************************************
   typedef enum logic [1:0] {DS_ACQ, DS_CONV, DS_READ} dcb_dev_state_e;
   typedef enum logic [1:0] {
      HS_IDLE, HS_WAIT_IRQ, HS_HIGH, HS_LOW
   } dcb_host_state_e;

endpackage

// ==== design/dcb_sync.sv ====
`timescale 1ns/1ps
module dcb_sync (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_async,
   output logic o_level,
   output logic o_rise,
   output logic o_fall
);
   logic meta_q;
   logic sync_q;
   logic prev_q;

   // ********************************************************************
   // two-flop synchroniser, edge detect on the second flop only
   // ********************************************************************
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         prev_q <= 1'b0;
      end else begin
         meta_q <= i_async;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   always_comb begin
      o_level = sync_q;
      o_rise = sync_q & ~prev_q;
      o_fall = ~sync_q & prev_q;
   end
endmodule

// ==== verification/dcb_link_chk.sv ====
`timescale 1ns/1ps
module dcb_link_chk (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic sample_trigger,
   input wire logic sclk,
   input wire logic chain_in,
   input wire logic chain_out
);
   // ****************************************
   // cycles since the trigger went high
   // ****************************************
   // saturates so a long read never wraps back into the busy window
   logic [7:0] age_q;
   logic [7:0] age_d;
   always_comb begin
      age_d = age_q;
      if (!sample_trigger) begin
         age_d = 8'h00;
      end else if (age_q != 8'hff) begin
         age_d = age_q + 8'h01;
      end
   end
   // sclk falls seen while the trigger stays high
   logic sclk_prev_q;
   logic [7:0] nfall_q;
   logic [7:0] nfall_d;
   always_comb begin
      nfall_d = nfall_q;
      if (!sample_trigger) begin
         nfall_d = 8'h00;
      end else if (sclk_prev_q && !sclk) begin
         nfall_d = nfall_q + 8'h01;
      end
   end
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         age_q <= 8'h00;
         sclk_prev_q <= 1'b1;
         nfall_q <= 8'h00;
      end else begin
         age_q <= age_d;
         sclk_prev_q <= sclk;
         nfall_q <= nfall_d;
      end
   end
   // ****************************************
   // link properties
   // ****************************************
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);
   sequence busy_s;
      $rose(chain_out) && sclk;
   endsequence
   sequence bit_hold_s;
      $stable(chain_out) [*4];
   endsequence
   idle_low_a: assert property (
      (!sample_trigger && !chain_in) [*5] |-> !chain_out)
      else $error("chain output not low while idle");
   trig_fall_a: assert property (
      $fell(sample_trigger) |-> ##[1:8] !chain_out)
      else $error("chain output not released after trigger fall");
   irq_time_a: assert property (
      busy_s |-> age_q >= 8'h32 && age_q <= 8'h3a)
      else $error("busy bit outside the conversion window");
   conv_quiet_a: assert property (
      sample_trigger && age_q < 8'h30 |-> !chain_out)
      else $error("chain output moved during conversion");
   irq_trig_a: assert property (
      $rose(chain_out) |-> sample_trigger)
      else $error("chain output rose without a conversion");
   busy_hold_a: assert property (
      busy_s |-> chain_out [*4])
      else $error("busy bit dropped before the first fall");
   valid_both_a: assert property (
      $rose(sclk) |-> bit_hold_s)
      else $error("data bit changed around the rising edge");
   trig_hold_a: assert property (
      $fell(sample_trigger) |-> nfall_q == 8'(dcb_pkg::TOTAL_FALLS))
      else $error("trigger dropped before all bits were read");
   shift_lag_a: assert property (
      $fell(sclk) |-> ##1 $stable(chain_out) [*2])
      else $error("data bit changed too soon after the fall");
endmodule

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
`define CHK(nm, ex, gt) \
   begin \
      samples_checked++; \
      if ((gt) !== (ex)) begin \
         error_cnt++; \
         $display("mismatch %s expected %h seen %h", nm, ex, gt); \
      end \
   end
module testbench;
   localparam int LIMIT = 20000;
   logic i_clk;
   logic i_rst_n;
   logic i_start;
   logic [dcb_pkg::RES_W-1:0] val_a, val_b, last_a, last_b, word;
   logic [dcb_pkg::RES_W-1:0] got [2];
   logic [dcb_pkg::IDX_W-1:0] word_idx;
   logic ready, irq_seen, word_valid, done, pu_b, rr_b, dm_a, dm_b, bm_b;
   logic pu_a, rr_a, bm_a;
   int error_cnt, samples_checked, cyc, falls, words;
   int pu_len, rr_cnt, irq_cnt, trig_cnt;
   dcb_link_if lnk_h ();
   dcb_link_if lnk_1 ();
   dcb_link_if lnk_2 ();
   assign lnk_1.sample_trigger = lnk_h.sample_trigger;
   assign lnk_2.sample_trigger = lnk_h.sample_trigger;
   assign lnk_1.sclk = lnk_h.sclk;
   assign lnk_2.sclk = lnk_h.sclk;
   assign lnk_1.chain_in = lnk_h.chain_in;
   assign lnk_2.chain_in = lnk_1.chain_out;
   assign lnk_h.chain_out = lnk_2.chain_out;
   dcb_host dcb_host_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .link(lnk_h),
      .i_start(i_start), .o_ready(ready), .o_irq_seen(irq_seen),
      .o_word(word), .o_word_valid(word_valid), .o_word_index(word_idx),
      .o_done(done));
   dcb_adc_dev dcb_adc_dev_1_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .link(lnk_1), .i_sample_value(val_a), .o_powered_up(pu_a),
      .o_daisy_mode(dm_a), .o_busy_mode(bm_a), .o_result_ready(rr_a),
      .o_last_result(last_a));
   dcb_adc_dev dcb_adc_dev_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .link(lnk_2), .i_sample_value(val_b), .o_powered_up(pu_b),
      .o_daisy_mode(dm_b), .o_busy_mode(bm_b), .o_result_ready(rr_b),
      .o_last_result(last_b));
   dcb_link_chk dcb_link_chk_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .sample_trigger(lnk_2.sample_trigger), .sclk(lnk_2.sclk),
      .chain_in(lnk_2.chain_in), .chain_out(lnk_2.chain_out));
   initial begin
      i_clk = 1'b0;
      forever #10 i_clk = ~i_clk;
   end
   // ****************************************
   // monitors, sampled away from the launch edge
   // ****************************************
   always @(negedge i_clk) begin
      cyc++;
      if (word_valid === 1'b1) begin
         got[word_idx[0]] = word;
         words++;
      end
      if (pu_b === 1'b1) pu_len++;
      if (rr_b === 1'b1) rr_cnt++;
      if (rr_a === 1'b1) rr_cnt++;
      if (irq_seen === 1'b1) irq_cnt++;
      if (cyc > LIMIT) begin
         error_cnt++;
         results();
      end
   end
   always @(negedge lnk_h.sclk) if (lnk_h.sample_trigger === 1'b1) falls++;
   always @(posedge lnk_h.sample_trigger) trig_cnt++;
   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // one full chain read; hold keeps i_start up to show it is refused
   task automatic run(input logic [17:0] a, input logic [17:0] b,
         input bit hold);
      int n;
      @(posedge i_clk);
      n = 0;
      words = 0;
      falls = 0;
      pu_len = 0;
      rr_cnt = 0;
      irq_cnt = 0;
      trig_cnt = 0;
      val_a <= a;
      val_b <= b;
      while (ready !== 1'b1 && n < 100) begin
         @(negedge i_clk);
         n++;
      end
      @(posedge i_clk);
      i_start <= 1'b1;
      if (!hold) begin
         @(posedge i_clk);
         i_start <= 1'b0;
      end
      n = 0;
      while (done !== 1'b1 && n < 2000) begin
         @(negedge i_clk);
         n++;
      end
      @(posedge i_clk);
      i_start <= 1'b0;
      `CHK("words", 2, words)
      `CHK("falls", dcb_pkg::TOTAL_FALLS, falls)
      `CHK("trigger rises", 1, trig_cnt)
      `CHK("irq", 1, irq_cnt)
      `CHK("conv length", dcb_pkg::CONV_CYCLES, pu_len)
      `CHK("result pulse", dcb_pkg::CHAIN_DEVICES, rr_cnt)
      `CHK("last word", b, got[0])
      `CHK("upstream word", a, got[1])
      `CHK("daisy", 2'b11, {dm_a, dm_b})
      `CHK("busy mode", 2'b11, {bm_a, bm_b})
   endtask
   task automatic sc_reset();
      int n;
      logic [3:0] idle;
      n = 0;
      @(negedge i_clk);
      idle = {lnk_h.sample_trigger, lnk_h.sclk, lnk_h.chain_in,
         lnk_h.chain_out};
      `CHK("idle link", 4'b0100, idle)
      `CHK("ready early", 1'b0, ready)
      while (ready !== 1'b1 && n < 50) begin
         @(negedge i_clk);
         n++;
      end
      `CHK("ready delay", dcb_pkg::SCLK_HALF_CYCLES, n)
   endtask
   task automatic sc_extremes();
      run(18'h3_ffff, 18'h0_0000, 1'b0);
      run(18'h0_0000, 18'h3_ffff, 1'b0);
      run(18'h2_0001, 18'h0_0003, 1'b0);
   endtask
   task automatic sc_acquire();
      run(18'h2_aaaa, 18'h1_5555, 1'b0);
      val_a <= 18'h0_0f0f;
      val_b <= 18'h3_0303;
      repeat (20) @(negedge i_clk);
      `CHK("held a", 18'h2_aaaa, last_a)
      `CHK("held b", 18'h1_5555, last_b)
      `CHK("powered down", 2'b00, {pu_a, pu_b})
      `CHK("chain idle", 2'b00, {lnk_1.chain_out, lnk_2.chain_out})
   endtask
   task automatic sc_start_held();
      run(18'h1_2345, 18'h2_b9b9, 1'b1);
      run(18'h3_0001, 18'h1_8000, 1'b0);
   endtask
   initial begin
      i_rst_n = 1'b0;
      i_start = 1'b0;
      val_a = 18'h0_0000;
      val_b = 18'h0_0000;
      error_cnt = 0;
      samples_checked = 0;
      cyc = 0;
      repeat (12) @(posedge i_clk);
      i_rst_n <= 1'b1;
      sc_reset();
      sc_extremes();
      sc_acquire();
      sc_start_held();
      results();
   end
endmodule
